/* fsd_logger.sv */
// Behavioural model of the companion logger that captures status frames.
`timescale 1ns/1ps
module fsd_logger (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] fault_lane_i,
	input wire logic dump_start_strobe_i,
	output logic [23:0] frame_o,
	output logic [7:0] frames_o
);
	logic [2:0] step;
	// Once the strobe is seen, all lanes are sampled on six clocks in a row.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			step <= 3'h0;
			frame_o <= 24'h000000;
			frames_o <= 8'h00;
		end
		else if (step != 3'h0 || dump_start_strobe_i)
		begin
			frame_o <= {frame_o[19:0], fault_lane_i};
			step <= (step == 3'h5) ? 3'h0 : step + 3'h1;
			if (step == 3'h5)
				frames_o <= frames_o + 8'h01;
		end
	end
endmodule

/* fsd_monitor.sv */
// Port checker for the fault status dump sequencer.
`timescale 1ns/1ps
module fsd_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rail_above_upper_i,
	input wire logic rail_above_lower_i,
	input wire logic logging_enable_in_i,
	input wire logic exception_i,
	input wire logic rail_in_window_o,
	input wire logic rail_below_window_o,
	input wire logic status_dump_req_n_o,
	input wire logic [3:0] fault_lane_o,
	input wire logic dump_start_strobe_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ********
	// Dump shape
	// ********
	// The request stays low seven clocks and the strobe marks the second to fifth of them.
	sequence s_req_low;
		!status_dump_req_n_o [*7] ##1 status_dump_req_n_o;
	endsequence
	sequence s_strobe;
		!dump_start_strobe_o ##1 dump_start_strobe_o [*4] ##1 !dump_start_strobe_o [*3];
	endsequence
	sequence s_quiet;
		(!rail_in_window_o && logging_enable_in_i && !exception_i) [*6];
	endsequence
	a_req_length: assert property ($fell(status_dump_req_n_o) |-> s_req_low)
		else $error("dump request low time wrong");
	a_strobe_shape: assert property ($fell(status_dump_req_n_o) |-> s_strobe)
		else $error("start strobe shape wrong");
	a_strobe_req: assert property (dump_start_strobe_o |-> !status_dump_req_n_o)
		else $error("strobe outside a dump");
	a_lanes_idle: assert property (status_dump_req_n_o |-> fault_lane_o == 4'h0)
		else $error("lanes busy while idle");
	a_start_cause: assert property ($fell(status_dump_req_n_o) |->
		$past(!rail_in_window_o && logging_enable_in_i || exception_i))
		else $error("dump started without cause");
	a_recov_hold: assert property ($rose(status_dump_req_n_o) ##0 s_quiet |->
		status_dump_req_n_o)
		else $error("dump repeated during recovery wait");
	// ********
	// Window flags and bus answer
	// ********
	a_window_flag: assert property ($past(!rst_i) |->
		rail_in_window_o == $past(rail_above_lower_i && !rail_above_upper_i))
		else $error("in window flag wrong");
	a_below_flag: assert property ($past(!rst_i) |->
		rail_below_window_o == $past(!rail_above_lower_i))
		else $error("below window flag wrong");
	a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer timing wrong");
endmodule

bind fsd_top fsd_monitor u_fsd_monitor (
	.clk_i(clk_i), .rst_i(rst_i), .rail_above_upper_i(rail_above_upper_i),
	.rail_above_lower_i(rail_above_lower_i), .logging_enable_in_i(logging_enable_in_i),
	.exception_i(exception_i), .rail_in_window_o(rail_in_window_o),
	.rail_below_window_o(rail_below_window_o), .status_dump_req_n_o(status_dump_req_n_o),
	.fault_lane_o(fault_lane_o), .dump_start_strobe_o(dump_start_strobe_o),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o)
);

/* fsd_pkg.sv */
// Constants and types shared by the fault status dump sequencer.
package fsd_pkg;
	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int CLK_HZ = 25000000;
	localparam int RECOV_TIME_US = 1966080;
	localparam int RECOV_CYCLES = RECOV_TIME_US * (CLK_HZ / 1000000);
	localparam int TIMER_W = 26;
	localparam int TRANSFER_CYCLES = 6;

	// ************************************************************
	// Dump counter values
	// ************************************************************
	localparam logic [2:0] CNT_IDLE = 3'h3;
	localparam logic [2:0] CNT_DONE = 3'h2;
	localparam logic [2:0] CNT_STEP_XOR = 3'h4;
	localparam int LANES = 4;

	// ************************************************************
	// FIFO shape
	// ************************************************************
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 16;
	localparam int LEVEL_W = 5;

	// ************************************************************
	// Register map, byte addresses
	// ************************************************************
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_DUMPS = 4'h8;
	localparam logic [3:0] REG_DATA = 4'hc;
	localparam int CTRL_LOG_EN = 0;
	localparam int CTRL_EXC_LOG = 1;
	localparam logic [1:0] CTRL_RESET = 2'h3;
	localparam int ST_REQ_N = 3;
	localparam int ST_IN_WIN = 4;
	localparam int ST_BELOW = 5;
	localparam int ST_CNT = 8;
	localparam int ST_LEVEL = 16;
	localparam int DATA_VALID = 8;

	// ************************************************************
	// Sequencer states
	// ************************************************************
	typedef enum logic [2:0] {
		FSD_WAIT_FAULT = 3'h0,
		FSD_REQ_DUMP = 3'h1,
		FSD_WAIT_RECOV = 3'h2,
		FSD_RETURN = 3'h3,
		FSD_SHUTDOWN = 3'h4
	} fsd_state_t;
endpackage

/* fsd_top.sv */
// Fault status dump sequencer with its FIFO and Wishbone register slave.
// What this block does
// - rail_in_window high only while rail lies between both thresholds.
// - rail_below_window high whenever rail is beneath the lower threshold.
// - Wait in fault-wait until rail out of window and logging enabled.
// - Leaving fault-wait drives status_dump_req_n low to start the transfer.
// - Then wait for rail back in window, logging off, or timer expiry.
// - Timer expiry returns directly; a logic condition passes one extra step.
// - Only fault-wait and recovery-wait accept the exception into shutdown.
// - A catastrophic exception also triggers a fault log dump.
// - Send 24 status bits: ten channels both comparators plus four rail bits.
// - Send bits serially on four lanes, one bit per lane each step.
// - A three-bit dump counter selects the bits on the lanes.
// - While status_dump_req_n is high the counter is held at 3.
// - The counter advances only while status_dump_req_n is low.
// - The counter steps once per clock through 4, 5, 6, 7, 0, 1.
// - At count 2 status_dump_req_n returns high, resetting the counter.
// - dump_start_strobe follows the counter's top bit.
// - Third lane carries rail_in_window at 000 and rail_below_window at 001.
// - A transfer occupies six clocks; the logger samples each of them.
//
// The register offsets and register access over Wishbone were decided locally.
`timescale 1ns/1ps

// ************************************************************
// Parameterised synchronous FIFO
// ************************************************************
module fsd_fifo #(
	parameter int W = 8,
	parameter int D = 16,
	parameter int AW = $clog2(D)
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o,
	output logic [AW:0] level_o
);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] level;
	} fsd_fifo_reg_t;

	fsd_fifo_reg_t r;
	fsd_fifo_reg_t next_r;
	logic push;
	logic pop;

	// Full and empty come straight from the stored level.
	assign in_ready_o = (r.level != (AW+1)'(D));
	assign out_valid_o = (r.level != '0);
	assign out_data_o = r.mem[r.rd];
	assign level_o = r.level;
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// Pointer and level update for a push, a pop or both.
	always_comb
	begin
		next_r = r;
		if (push)
		begin
			next_r.mem[r.wr] = in_data_i;
			next_r.wr = r.wr + 1'b1;
		end
		if (pop)
		begin
			next_r.rd = r.rd + 1'b1;
		end
		if (push && !pop)
		begin
			next_r.level = r.level + 1'b1;
		end
		else if (pop && !push)
		begin
			next_r.level = r.level - 1'b1;
		end
	end

	// State register.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			r <= '0;
		end
		else
		begin
			r <= next_r;
		end
	end
endmodule

// ************************************************************
// Sequencer, dump counter, lane selector and register slave
// ************************************************************
module fsd_top #(
	parameter int RECOV_CYCLES = fsd_pkg::RECOV_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rail_above_upper_i,
	input wire logic rail_above_lower_i,
	input wire logic logging_enable_in_i,
	input wire logic exception_i,
	input wire logic [8:0] chan_a_i,
	input wire logic [8:0] chan_b_i,
	input wire logic hotswap_rail_high_i,
	input wire logic hotswap_rail_low_i,
	input wire logic input_rail_good_i,
	input wire logic input_rail_minimum_i,
	output logic rail_in_window_o,
	output logic rail_below_window_o,
	output logic status_dump_req_n_o,
	output logic [3:0] fault_lane_o,
	output logic dump_start_strobe_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	typedef struct packed {
		fsd_pkg::fsd_state_t st;
		logic req_n;
		logic [2:0] cnt;
		logic [3:0] lanes;
		logic in_win;
		logic below;
		logic live;
		logic [fsd_pkg::TIMER_W-1:0] tmr;
		logic log_en;
		logic exc_log;
		logic [15:0] dumps;
		logic ack;
		logic [31:0] dat;
	} fsd_top_reg_t;

	fsd_top_reg_t r;
	fsd_top_reg_t next_r;
	logic [fsd_pkg::LANES-1:0][5:0] lane_bits;
	logic [2:0] step;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [7:0] fifo_in_data;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [7:0] fifo_out_data;
	logic [fsd_pkg::LEVEL_W-1:0] fifo_level;
	logic wb_req;
	logic room;
	logic log_gate;
	logic fault_now;
	logic win_now;
	logic below_now;

	// Window comparator decode; both flags are registered once.
	assign win_now = rail_above_lower_i & ~rail_above_upper_i;
	assign below_now = ~rail_above_lower_i;

	// Twenty-four status bits, six per lane in counter step order.
	// Channel nine's pair is the window decode held in r.in_win and r.below.
	always_comb
	begin
		lane_bits[0] = {chan_b_i[2], chan_a_i[2], chan_b_i[1],
			chan_a_i[1], chan_b_i[0], chan_a_i[0]};
		lane_bits[1] = {chan_b_i[5], chan_a_i[5], chan_b_i[4],
			chan_a_i[4], chan_b_i[3], chan_a_i[3]};
		lane_bits[2] = {r.below, r.in_win, chan_b_i[7],
			chan_a_i[7], chan_b_i[6], chan_a_i[6]};
		lane_bits[3] = {input_rail_minimum_i, input_rail_good_i,
			hotswap_rail_low_i, hotswap_rail_high_i,
			chan_b_i[8], chan_a_i[8]};
	end

	// Dumps start only with room for a whole transfer in the FIFO.
	assign room = fifo_in_ready &&
		(fifo_level <= fsd_pkg::LEVEL_W'(fsd_pkg::FIFO_D - fsd_pkg::TRANSFER_CYCLES));
	assign log_gate = logging_enable_in_i & r.log_en;
	assign fault_now = ~r.in_win & log_gate & r.live; // Flags hold no real sample right after reset.
	assign wb_req = wb_cyc_i & wb_stb_i & ~r.ack;
	assign fifo_out_ready = wb_req & ~wb_we_i & (wb_adr_i == fsd_pkg::REG_DATA);

	// Next state of sequencer, counter, lanes and register slave.
	always_comb
	begin
		next_r = r;
		step = 3'h0;
		fifo_in_valid = 1'b0;
		next_r.in_win = win_now;
		next_r.below = below_now;
		next_r.live = 1'b1;

		// Sequencer loop around the fault-wait state.
		unique case (r.st)
			fsd_pkg::FSD_WAIT_FAULT:
			begin
				next_r.tmr = '0;
				if (exception_i)
				begin
					next_r.st = fsd_pkg::FSD_SHUTDOWN;
					if (r.exc_log && room && r.req_n)
					begin
						next_r.req_n = 1'b0;
					end
				end
				else if (fault_now && room && r.req_n)
				begin
					next_r.st = fsd_pkg::FSD_REQ_DUMP;
					next_r.req_n = 1'b0;
				end
			end
			fsd_pkg::FSD_REQ_DUMP:
			begin
				next_r.st = fsd_pkg::FSD_WAIT_RECOV;
			end
			fsd_pkg::FSD_WAIT_RECOV:
			begin
				next_r.tmr = r.tmr + 1'b1;
				if (exception_i)
				begin
					next_r.st = fsd_pkg::FSD_SHUTDOWN;
					if (r.exc_log && room && r.req_n)
					begin
						next_r.req_n = 1'b0;
					end
				end
				else if (r.tmr == fsd_pkg::TIMER_W'(RECOV_CYCLES - 1))
				begin
					next_r.st = fsd_pkg::FSD_WAIT_FAULT;
				end
				else if (r.in_win || !log_gate)
				begin
					next_r.st = fsd_pkg::FSD_RETURN;
				end
			end
			fsd_pkg::FSD_RETURN:
			begin
				next_r.st = fsd_pkg::FSD_WAIT_FAULT;
			end
			fsd_pkg::FSD_SHUTDOWN:
			begin
				next_r.tmr = '0;
				if (!exception_i)
				begin
					next_r.st = fsd_pkg::FSD_WAIT_FAULT;
				end
			end
			default:
			begin
				next_r.st = fsd_pkg::FSD_WAIT_FAULT;
			end
		endcase

		// Dump counter: held at 3 while idle, counting while requested.
		if (r.req_n)
		begin
			next_r.cnt = fsd_pkg::CNT_IDLE;
		end
		else
		begin
			next_r.cnt = r.cnt + 1'b1;
			if (next_r.cnt == fsd_pkg::CNT_DONE)
			begin
				next_r.req_n = 1'b1;
				next_r.cnt = fsd_pkg::CNT_IDLE;
			end
			else
			begin
				fifo_in_valid = 1'b1;
			end
		end
		if (!next_r.req_n && r.req_n)
		begin
			next_r.dumps = r.dumps + 1'b1;
		end

		// Lanes are registered from the count they will stand beside.
		step = next_r.cnt ^ fsd_pkg::CNT_STEP_XOR;
		for (int i = 0; i < fsd_pkg::LANES; i++)
		begin
			next_r.lanes[i] = 1'b0;
			if (step < 3'(fsd_pkg::TRANSFER_CYCLES) && next_r.cnt != fsd_pkg::CNT_IDLE)
			begin
				next_r.lanes[i] = lane_bits[i][step];
			end
		end

		// Wishbone slave: one wait state, every address acknowledged.
		next_r.ack = wb_req;
		next_r.dat = '0;
		if (wb_req && wb_we_i)
		begin
			if (wb_adr_i == fsd_pkg::REG_CTRL && wb_sel_i[0])
			begin
				next_r.log_en = wb_dat_i[fsd_pkg::CTRL_LOG_EN];
				next_r.exc_log = wb_dat_i[fsd_pkg::CTRL_EXC_LOG];
			end
			else if (wb_adr_i == fsd_pkg::REG_DUMPS)
			begin
				next_r.dumps = '0;
			end
		end
		else if (wb_req)
		begin
			unique case (wb_adr_i)
				fsd_pkg::REG_CTRL:
				begin
					next_r.dat[fsd_pkg::CTRL_LOG_EN] = r.log_en;
					next_r.dat[fsd_pkg::CTRL_EXC_LOG] = r.exc_log;
				end
				fsd_pkg::REG_STATUS:
				begin
					next_r.dat[2:0] = r.st;
					next_r.dat[fsd_pkg::ST_REQ_N] = r.req_n;
					next_r.dat[fsd_pkg::ST_IN_WIN] = r.in_win;
					next_r.dat[fsd_pkg::ST_BELOW] = r.below;
					next_r.dat[fsd_pkg::ST_CNT +: 3] = r.cnt;
					next_r.dat[fsd_pkg::ST_LEVEL +: fsd_pkg::LEVEL_W] = fifo_level;
				end
				fsd_pkg::REG_DUMPS:
				begin
					next_r.dat[15:0] = r.dumps;
				end
				fsd_pkg::REG_DATA:
				begin
					next_r.dat[7:0] = fifo_out_data;
					next_r.dat[fsd_pkg::DATA_VALID] = fifo_out_valid;
				end
				default:
				begin
					next_r.dat = '0;
				end
			endcase
		end
	end

	// Each pushed word is the count and lanes of one transfer step.
	assign fifo_in_data = {1'b0, next_r.cnt, next_r.lanes};

	// State register.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			r <= '0;
			r.st <= fsd_pkg::FSD_WAIT_FAULT;
			r.req_n <= 1'b1;
			r.cnt <= fsd_pkg::CNT_IDLE;
			r.log_en <= fsd_pkg::CTRL_RESET[fsd_pkg::CTRL_LOG_EN];
			r.exc_log <= fsd_pkg::CTRL_RESET[fsd_pkg::CTRL_EXC_LOG];
		end
		else
		begin
			r <= next_r;
		end
	end

	// Dump FIFO between the lanes and the register port.
	fsd_fifo #(
		.W(fsd_pkg::FIFO_W),
		.D(fsd_pkg::FIFO_D)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(fifo_in_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(fifo_in_data),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_out_data),
		.level_o(fifo_level)
	);

	// Outputs straight from flip-flops.
	assign rail_in_window_o = r.in_win;
	assign rail_below_window_o = r.below;
	assign status_dump_req_n_o = r.req_n;
	assign fault_lane_o = r.lanes;
	assign dump_start_strobe_o = r.cnt[2];
	assign wb_dat_o = r.dat;
	assign wb_ack_o = r.ack;
endmodule

/* fsd_top_bench.sv */
// Self-checking bench for the fault status dump sequencer.
`timescale 1ns/1ps
module fsd_top_bench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic rail_up = 1'b0, rail_lo = 1'b1, log_en = 1'b1, exc = 1'b0;
	logic [8:0] ch_a = 9'h15a, ch_b = 9'h0a5;
	logic hs_hi = 1'b1, hs_lo = 1'b0, in_good = 1'b1, in_min = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, win_o, below_o, req_n_o, strobe_o;
	logic [3:0] adr = 4'h0, lanes;
	logic [31:0] wdat = 32'h0, rd, rdat;
	logic [23:0] frame;
	logic [7:0] frames;
	int num_errors = 0;
	int checks = 0;
	// Design under test with a short recovery timer, and the logger model.
	fsd_top #(.RECOV_CYCLES(50)) u_fsd_top (
		.clk_i(clk_i), .rst_i(rst_i), .rail_above_upper_i(rail_up),
		.rail_above_lower_i(rail_lo), .logging_enable_in_i(log_en), .exception_i(exc),
		.chan_a_i(ch_a), .chan_b_i(ch_b), .hotswap_rail_high_i(hs_hi),
		.hotswap_rail_low_i(hs_lo), .input_rail_good_i(in_good), .input_rail_minimum_i(in_min),
		.rail_in_window_o(win_o), .rail_below_window_o(below_o), .status_dump_req_n_o(req_n_o),
		.fault_lane_o(lanes), .dump_start_strobe_o(strobe_o), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack)
	);
	fsd_logger u_fsd_logger (
		.clk_i(clk_i), .rst_i(rst_i), .fault_lane_i(lanes), .dump_start_strobe_i(strobe_o),
		.frame_o(frame), .frames_o(frames)
	);
	// Free-running 25 MHz clock.
	initial
	begin
		forever #20 clk_i = ~clk_i;
	end
	// ********
	// Shared tasks
	// ********
	// Counts every compare and reports a mismatch at once.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// One classic bus cycle, held until ack is sampled high.
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 50)
			check(32'h0, 32'h1);
		@(posedge clk_i);
	endtask
	// Waits a bounded time for the logger to hold n frames.
	task automatic wait_frames(input logic [7:0] n, output int t);
		t = 0;
		while (frames !== n && t < 400)
		begin
			@(posedge clk_i);
			t++;
		end
		check({24'h0, frames}, {24'h0, n});
	endtask
	// Frame the logger should capture for the present inputs.
	function automatic logic [23:0] exp_frame(input logic win, input logic low);
		return {ch_a[8], ch_a[6], ch_a[3], ch_a[0], ch_b[8], ch_b[6], ch_b[3], ch_b[0],
			hs_hi, ch_a[7], ch_a[4], ch_a[1], hs_lo, ch_b[7], ch_b[4], ch_b[1],
			in_good, win, ch_a[5], ch_a[2], in_min, low, ch_b[5], ch_b[2]};
	endfunction
	task automatic print_verdict();
		if (num_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ********
	// Test sequence
	// ********
	initial
	begin
		int t;
		logic [23:0] ef;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check({27'h0, req_n_o, lanes}, 32'h10);
		wb(1'b0, fsd_pkg::REG_STATUS, 32'h0);
		check(rd, 32'h318);
		wb(1'b1, 4'h6, 32'hffffffff);
		wb(1'b0, 4'h6, 32'h0);
		check(rd, 32'h0);
		wb(1'b0, fsd_pkg::REG_CTRL, 32'h0);
		check(rd, 32'h3);
		rail_lo <= 1'b0;
		wait_frames(8'h1, t);
		check({8'h0, frame}, {8'h0, exp_frame(1'b0, 1'b1)});
		wait_frames(8'h2, t);
		check({31'h0, t > 40}, 32'h1);
		repeat (150) @(posedge clk_i);
		check({24'h0, frames}, 32'h2);
		wb(1'b0, fsd_pkg::REG_STATUS, 32'h0);
		check({27'h0, rd[20:16]}, 32'hc);
		wb(1'b0, fsd_pkg::REG_DUMPS, 32'h0);
		check(rd, 32'h2);
		rail_lo <= 1'b1;
		repeat (4) @(posedge clk_i);
		ef = exp_frame(1'b0, 1'b1);
		wb(1'b0, fsd_pkg::REG_DATA, 32'h0);
		check(rd, {23'h0, 1'b1, 1'b0, 3'h4, ef[23:20]});
		repeat (11) wb(1'b0, fsd_pkg::REG_DATA, 32'h0);
		wb(1'b0, fsd_pkg::REG_DATA, 32'h0);
		check({31'h0, rd[8]}, 32'h0);
		// A fault ended by the rail coming back takes the extra step, well before the timer.
		rail_lo <= 1'b0;
		wait_frames(8'h3, t);
		rail_lo <= 1'b1;
		repeat (4) @(posedge clk_i);
		rail_lo <= 1'b0;
		wait_frames(8'h4, t);
		check({31'h0, t < 40}, 32'h1);
		// Logging switched off ends the recovery wait and blocks new dumps.
		log_en <= 1'b0;
		repeat (30) @(posedge clk_i);
		check({24'h0, frames}, 32'h4);
		repeat (12) wb(1'b0, fsd_pkg::REG_DATA, 32'h0);
		wb(1'b1, fsd_pkg::REG_DUMPS, 32'h0);
		wb(1'b0, fsd_pkg::REG_DUMPS, 32'h0);
		check(rd, 32'h0);
		// An exception with exception logging off shuts down without a dump.
		wb(1'b1, fsd_pkg::REG_CTRL, 32'h1);
		exc <= 1'b1;
		repeat (20) @(posedge clk_i);
		check({24'h0, frames}, 32'h4);
		wb(1'b0, fsd_pkg::REG_STATUS, 32'h0);
		check({29'h0, rd[2:0]}, 32'h4);
		exc <= 1'b0;
		repeat (3) @(posedge clk_i);
		wb(1'b1, fsd_pkg::REG_CTRL, 32'h3);
		exc <= 1'b1;
		wait_frames(8'h5, t);
		wb(1'b0, fsd_pkg::REG_STATUS, 32'h0);
		check({29'h0, rd[2:0]}, 32'h4);
		wb(1'b0, fsd_pkg::REG_DUMPS, 32'h0);
		check(rd, 32'h1);
		exc <= 1'b0;
		rail_lo <= 1'b1;
		repeat (5) @(posedge clk_i);
		print_verdict();
	end
	// Cuts a hang short well beyond the expected run time.
	initial
	begin
		repeat (5000) @(posedge clk_i);
		num_errors++;
		print_verdict();
	end
endmodule
